// *** design/acb_core.sv ***
// combinational signed adder/subtractor with carry, borrow and zero flags
// assumes operands in the low 16 bits when the narrow width is chosen
`default_nettype none

module acb_core (
   input  wire logic        wide,
   input  wire logic        sub,
   input  wire logic [31:0] opnd_a,
   input  wire logic [31:0] opnd_b,
   output logic      [31:0] word,
   output logic             carry,
   output logic             borrow,
   output logic             zero
);

   // sign-extends an operand of the chosen width to 33 bits
   function automatic logic signed [32:0] sext(input logic w, input logic [31:0] v);
      if (w)
         sext = {v[31], v};
      else
         sext = {{17{v[15]}}, v[15:0]};
   endfunction

   logic signed [32:0] true_sum;
   logic               fold;

   // exact result; 33 bits always hold it, for either width
   assign true_sum = sub ? (sext(wide, opnd_a) - sext(wide, opnd_b))
                         : (sext(wide, opnd_a) + sext(wide, opnd_b));

   // flags against the limits of the chosen width
   always_comb begin
      if (wide) begin
         carry  = true_sum > acb_pkg::ACB_POS32;
         borrow = true_sum < acb_pkg::ACB_NEG32;
      end else begin
         carry  = true_sum > acb_pkg::ACB_POS16;
         borrow = true_sum < acb_pkg::ACB_NEG16;
      end
   end

   // out of range: flip the msb so the word plus the flag weight is exact
   assign fold = carry | borrow;

   always_comb begin
      if (wide)
         word = {true_sum[31] ^ fold, true_sum[30:0]};
      else
         word = {16'h0000, true_sum[15] ^ fold, true_sum[14:0]};
   end

   // zero only for an exact zero result
   assign zero = (word == 32'h0000_0000) && !fold;

endmodule // acb_core

`default_nettype wire

// *** design/acb_pkg.sv ***
// package for the add/subtract unit with carry and borrow flags
// assumes a single clock domain and a 32-bit AXI4-Lite register port
`default_nettype none

package acb_pkg;

   // register bus geometry and answers
   localparam int         ACB_AW         = 8;
   localparam logic [1:0] ACB_RESP_OKAY  = 2'h0;
   localparam logic [1:0] ACB_RESP_SLV   = 2'h2;

   // register byte offsets
   localparam logic [7:0] ACB_OFF_CTRL   = 8'h00;
   localparam logic [7:0] ACB_OFF_OPA    = 8'h04;
   localparam logic [7:0] ACB_OFF_OPB    = 8'h08;
   localparam logic [7:0] ACB_OFF_CMD    = 8'h0C;
   localparam logic [7:0] ACB_OFF_RESULT = 8'h10;
   localparam logic [7:0] ACB_OFF_FLAGS  = 8'h14;
   localparam logic [7:0] ACB_OFF_ISTAT  = 8'h18;
   localparam logic [7:0] ACB_OFF_IMASK  = 8'h1C;

   // field positions
   localparam int ACB_CTRL_WIDE   = 0;
   localparam int ACB_CTRL_SUB    = 1;
   localparam int ACB_CMD_START   = 0;
   localparam int ACB_FLAG_CARRY  = 0;
   localparam int ACB_FLAG_BORROW = 1;
   localparam int ACB_FLAG_ZERO   = 2;
   localparam int ACB_EV_DONE     = 0;
   localparam int ACB_EV_CARRY    = 1;
   localparam int ACB_EV_BORROW   = 2;
   localparam int ACB_EV_W        = 3;
   localparam int ACB_HALF        = 16;

   // reset values
   localparam logic [31:0]         ACB_CTRL_RST = 32'h0000_0000;
   localparam logic [ACB_EV_W-1:0] ACB_MASK_RST = 3'h0;

   // range limits of the result word, on a 33-bit signed scale
   localparam logic signed [32:0] ACB_POS16 = 33'sh0_0000_7FFF;
   localparam logic signed [32:0] ACB_NEG16 = 33'sh1_FFFF_8000;
   localparam logic signed [32:0] ACB_POS32 = 33'sh0_7FFF_FFFF;
   localparam logic signed [32:0] ACB_NEG32 = 33'sh1_8000_0000;

   // weight of an asserted carry or borrow, on a 34-bit signed scale
   localparam logic signed [33:0] ACB_WT16 = 34'sh0_0000_8000;
   localparam logic signed [33:0] ACB_WT32 = 34'sh0_8000_0000;

endpackage : acb_pkg

`default_nettype wire

// *** design/acb_unit.sv ***
// add/subtract unit with carry and borrow flags, executor port and AXI4-Lite registers
// assumes one clock aclk, a synchronous active-low reset and a well-behaved bus master
//
// The register addresses and the AXI4-Lite register port were decided locally.
`default_nettype none

module acb_unit (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // register bus
   input  wire logic [acb_pkg::ACB_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [acb_pkg::ACB_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // executor request
   input  wire logic                       exe_req,
   input  wire logic                       exe_sub,
   input  wire logic                       exe_wide,
   input  wire logic [31:0]                exe_opnd_a,
   input  wire logic [31:0]                exe_opnd_b,
   // result and flag_result_bits
   output logic                            res_valid,
   output logic [31:0]                     res_word,
   output logic                            res_carry,
   output logic                            res_borrow,
   output logic                            res_zero,
   output logic                            irq
);

   // true when an address names the register at the given offset
   function automatic logic hit(input logic [acb_pkg::ACB_AW-1:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
   endfunction

   // true for an offset that a register occupies
   function automatic logic mapped(input logic [acb_pkg::ACB_AW-1:0] a);
      mapped = hit(a, acb_pkg::ACB_OFF_CTRL)   || hit(a, acb_pkg::ACB_OFF_OPA)   ||
               hit(a, acb_pkg::ACB_OFF_OPB)    || hit(a, acb_pkg::ACB_OFF_CMD)   ||
               hit(a, acb_pkg::ACB_OFF_RESULT) || hit(a, acb_pkg::ACB_OFF_FLAGS) ||
               hit(a, acb_pkg::ACB_OFF_ISTAT)  || hit(a, acb_pkg::ACB_OFF_IMASK);
   endfunction

   logic [acb_pkg::ACB_AW-1:0]  awaddr_reg;
   logic                        aw_held_reg;
   logic [31:0]                 wdata_reg;
   logic [3:0]                  wstrb_reg;
   logic                        w_held_reg;
   logic                        bvalid_reg;
   logic [1:0]                  bresp_reg;
   logic                        rvalid_reg;
   logic [1:0]                  rresp_reg;
   logic [31:0]                 rdata_reg;
   logic [31:0]                 ctrl_reg;
   logic [31:0]                 opa_reg;
   logic [31:0]                 opb_reg;
   logic                        sw_pend_reg;
   logic [acb_pkg::ACB_EV_W-1:0] istat_reg;
   logic [acb_pkg::ACB_EV_W-1:0] imask_reg;
   logic [acb_pkg::ACB_EV_W-1:0] istat_next;
   logic [acb_pkg::ACB_EV_W-1:0] ev_set;
   logic                        wr_do;
   logic                        rd_do;
   logic                        cmd_start;
   logic                        start;
   logic                        sel_wide;
   logic                        sel_sub;
   logic [31:0]                 sel_a;
   logic [31:0]                 sel_b;
   logic [31:0]                 core_word;
   logic                        core_carry;
   logic                        core_borrow;
   logic                        core_zero;
   logic [31:0]                 rd_mux;

   // handshake outputs
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   // a write completes once address and data are both held
   assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
   assign rd_do = s_axi_arvalid && s_axi_arready;
   assign cmd_start = wr_do && hit(awaddr_reg, acb_pkg::ACB_OFF_CMD) &&
                      wstrb_reg[0] && wdata_reg[acb_pkg::ACB_CMD_START];

   // write address channel, taken in any order with data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_held_reg <= 1'b0;
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata;
         wstrb_reg  <= s_axi_wstrb;
      end else if (wr_do) begin
         w_held_reg <= 1'b0;
      end
   end

   // write response, error for an unmapped offset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= acb_pkg::ACB_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= mapped(awaddr_reg) ? acb_pkg::ACB_RESP_OKAY : acb_pkg::ACB_RESP_SLV;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // software-writable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg  <= acb_pkg::ACB_CTRL_RST;
         opa_reg   <= 32'h0000_0000;
         opb_reg   <= 32'h0000_0000;
         imask_reg <= acb_pkg::ACB_MASK_RST;
      end else if (wr_do) begin
         if (hit(awaddr_reg, acb_pkg::ACB_OFF_CTRL))
            ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg)
                        & {30'h0000_0000, 2'h3};
         if (hit(awaddr_reg, acb_pkg::ACB_OFF_OPA))
            opa_reg <= merge(opa_reg, wdata_reg, wstrb_reg);
         if (hit(awaddr_reg, acb_pkg::ACB_OFF_OPB))
            opb_reg <= merge(opb_reg, wdata_reg, wstrb_reg);
         if (hit(awaddr_reg, acb_pkg::ACB_OFF_IMASK) && wstrb_reg[0])
            imask_reg <= wdata_reg[acb_pkg::ACB_EV_W-1:0];
      end
   end

   // software start waits while the executor holds the unit
   always_ff @(posedge aclk) begin
      if (!aresetn)
         sw_pend_reg <= 1'b0;
      else if (cmd_start)
         sw_pend_reg <= 1'b1;
      else if (!exe_req)
         sw_pend_reg <= 1'b0;
   end

   // operand selection, executor first
   assign start    = exe_req || sw_pend_reg;
   assign sel_wide = exe_req ? exe_wide   : ctrl_reg[acb_pkg::ACB_CTRL_WIDE];
   assign sel_sub  = exe_req ? exe_sub    : ctrl_reg[acb_pkg::ACB_CTRL_SUB];
   assign sel_a    = exe_req ? exe_opnd_a : opa_reg;
   assign sel_b    = exe_req ? exe_opnd_b : opb_reg;

   // signed arithmetic and flag derivation
   acb_core u_core (
      .wide   (sel_wide),
      .sub    (sel_sub),
      .opnd_a (sel_a),
      .opnd_b (sel_b),
      .word   (core_word),
      .carry  (core_carry),
      .borrow (core_borrow),
      .zero   (core_zero)
   );

   // word and flags latch together on a request, then hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_word   <= 32'h0000_0000;
         res_carry  <= 1'b0;
         res_borrow <= 1'b0;
         res_zero   <= 1'b0;
      end else if (start) begin
         res_word   <= core_word;
         res_carry  <= core_carry;
         res_borrow <= core_borrow;
         res_zero   <= core_zero;
      end
   end

   // one-cycle marker that new results stand
   always_ff @(posedge aclk) begin
      if (!aresetn)
         res_valid <= 1'b0;
      else
         res_valid <= start;
   end

   // sticky events, write one to clear, a new event beats the clear
   always_comb begin
      ev_set = '0;
      ev_set[acb_pkg::ACB_EV_DONE]   = res_valid;
      ev_set[acb_pkg::ACB_EV_CARRY]  = res_valid && res_carry;
      ev_set[acb_pkg::ACB_EV_BORROW] = res_valid && res_borrow;
      istat_next = istat_reg;
      if (wr_do && hit(awaddr_reg, acb_pkg::ACB_OFF_ISTAT) && wstrb_reg[0])
         istat_next = istat_reg & ~wdata_reg[acb_pkg::ACB_EV_W-1:0];
      istat_next = istat_next | ev_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         istat_reg <= '0;
      else
         istat_reg <= istat_next;
   end

   // level interrupt from unmasked events
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(istat_next & imask_reg);
   end

   // read data selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(s_axi_araddr, acb_pkg::ACB_OFF_CTRL))
         rd_mux = ctrl_reg;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_OPA))
         rd_mux = opa_reg;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_OPB))
         rd_mux = opb_reg;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_CMD))
         rd_mux[acb_pkg::ACB_CMD_START] = sw_pend_reg;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_RESULT))
         rd_mux = res_word;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_FLAGS)) begin
         rd_mux[acb_pkg::ACB_FLAG_CARRY]  = res_carry;
         rd_mux[acb_pkg::ACB_FLAG_BORROW] = res_borrow;
         rd_mux[acb_pkg::ACB_FLAG_ZERO]   = res_zero;
      end else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_ISTAT))
         rd_mux[acb_pkg::ACB_EV_W-1:0] = istat_reg;
      else if (hit(s_axi_araddr, acb_pkg::ACB_OFF_IMASK))
         rd_mux[acb_pkg::ACB_EV_W-1:0] = imask_reg;
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= acb_pkg::ACB_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_do) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= mapped(s_axi_araddr) ? acb_pkg::ACB_RESP_OKAY : acb_pkg::ACB_RESP_SLV;
         rdata_reg  <= rd_mux;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // checking model: exact result of the taken request and the width used
   logic signed [33:0] chk_true_reg;
   logic               chk_wide_reg;
   logic signed [33:0] chk_recon;
   logic signed [33:0] chk_pos;
   logic signed [33:0] chk_neg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chk_true_reg <= '0;
         chk_wide_reg <= 1'b0;
      end else if (start) begin
         chk_wide_reg <= sel_wide;
         if (sel_wide)
            chk_true_reg <= sel_sub ? (34'(signed'(sel_a)) - 34'(signed'(sel_b)))
                                    : (34'(signed'(sel_a)) + 34'(signed'(sel_b)));
         else
            chk_true_reg <= sel_sub
               ? (34'(signed'(sel_a[15:0])) - 34'(signed'(sel_b[15:0])))
               : (34'(signed'(sel_a[15:0])) + 34'(signed'(sel_b[15:0])));
      end
   end

   // word read back as signed plus the weight of the flags
   always_comb begin
      if (chk_wide_reg) begin
         chk_pos   = 34'(acb_pkg::ACB_POS32);
         chk_neg   = 34'(acb_pkg::ACB_NEG32);
         chk_recon = 34'(signed'(res_word))
                   + (res_carry ? acb_pkg::ACB_WT32 : 34'sh0)
                   - (res_borrow ? acb_pkg::ACB_WT32 : 34'sh0);
      end else begin
         chk_pos   = 34'(acb_pkg::ACB_POS16);
         chk_neg   = 34'(acb_pkg::ACB_NEG16);
         chk_recon = 34'(signed'(res_word[15:0]))
                   + (res_carry ? acb_pkg::ACB_WT16 : 34'sh0)
                   - (res_borrow ? acb_pkg::ACB_WT16 : 34'sh0);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   recon_exact_a: assert property (res_valid |-> chk_recon == chk_true_reg)
      else $error("word plus flag weight differs from true result");
   signed_sum_a: assert property (res_valid |-> (chk_true_reg < 0) ==
      (res_borrow || (!res_carry && (chk_wide_reg ? res_word[31] : res_word[15]))))
      else $error("signed result misread");
   carry_limit_a: assert property (res_valid |-> res_carry == (chk_true_reg > chk_pos))
      else $error("carry flag disagrees with positive limit");
   borrow_limit_a: assert property (res_valid |-> res_borrow == (chk_true_reg < chk_neg))
      else $error("borrow flag disagrees with negative limit");
   flags_apart_a: assert property (!(res_carry && res_borrow))
      else $error("carry and borrow both set");
   carry_weight_a: assert property (res_valid && res_carry |-> chk_recon - chk_true_reg == 0 && !res_word[chk_wide_reg ? 31 : 15] == (chk_true_reg[16] ^ chk_true_reg[15]) | chk_wide_reg)
      else $error("carry weight wrong");
   borrow_word_a: assert property (res_valid && res_borrow |-> (chk_wide_reg ? res_word[31] : res_word[15]))
      else $error("borrow word msb clear");
   neg_msb_a: assert property (res_valid && chk_true_reg < 0 |-> (chk_wide_reg ? res_word[31] : res_word[15]))
      else $error("negative result with msb zero");
   narrow_word_a: assert property (res_valid && !chk_wide_reg |-> res_word[31:16] == 16'h0000)
      else $error("narrow result has upper bits set");
   zero_flag_a: assert property (res_valid |-> res_zero == (chk_true_reg == 0))
      else $error("zero flag wrong");
   update_now_a: assert property (exe_req |=> res_valid)
      else $error("request not answered next cycle");
   hold_a: assert property (!start |=> $stable(res_word) && $stable(res_carry) && $stable(res_borrow))
      else $error("result changed without a request");
   irq_level_a: assert property (irq == |($past(istat_next) & $past(imask_reg)))
      else $error("interrupt level wrong");

   carry_seen_c: cover property (res_valid && res_carry);
   borrow_seen_c: cover property (res_valid && res_borrow);
   zero_seen_c: cover property (res_valid && res_zero);
   sw_defer_c: cover property (exe_req && sw_pend_reg ##1 !exe_req && sw_pend_reg);

endmodule // acb_unit

`default_nettype wire

// *** test/acb_exec_model.sv ***
// executor partner model: issues flagged add/subtract requests
// assumes the bench calls its tasks right after a rising edge of aclk
`default_nettype none

module acb_exec_model (
   output logic        exe_req,
   output logic        exe_sub,
   output logic        exe_wide,
   output logic [31:0] exe_opnd_a,
   output logic [31:0] exe_opnd_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle with meaningless operands
   initial begin
      exe_req    = 1'b0;
      exe_sub    = 1'b0;
      exe_wide   = 1'b0;
      exe_opnd_a = 32'h5A5A_5A5A;
      exe_opnd_b = 32'hA5A5_A5A5;
   end

   // one op per call; the flagged op is chosen as the flags are used
   task automatic issue(input logic s, input logic w, input logic [63:0] ab);
      exe_req    <= 1'b1;
      exe_sub    <= s;
      exe_wide   <= w;
      exe_opnd_a <= ab[63:32];
      exe_opnd_b <= ab[31:0];
   endtask

   // no request: operands scramble so stale values cannot pass
   task automatic rest();
      exe_req    <= 1'b0;
      exe_opnd_a <= ~exe_opnd_a;
      exe_opnd_b <= ~exe_opnd_b;
   endtask
endmodule // acb_exec_model

`default_nettype wire

// *** test/acb_unit_test.sv ***
// self-checking bench for the add/subtract unit
// assumes the executor model beside the unit and a 50 MHz clock
`default_nettype none

module acb_unit_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, req, sub, wide, vld, cry, brw, zro, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, opa, opb, word;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          fail_count = 0;
   int          checks = 0;
   logic [65:0] cs [9] = '{
      {2'b00, 32'h0000_7FFF, 32'h0000_0001}, {2'b10, 32'h0000_8000, 32'h0000_0001},
      {2'b00, 32'hABCD_0001, 32'h1234_FFFF}, {2'b10, 32'h0000_0005, 32'h0000_0007},
      {2'b01, 32'h7FFF_FFFF, 32'h0000_0001}, {2'b11, 32'h8000_0000, 32'h0000_0001},
      {2'b01, 32'h8000_0000, 32'h8000_0000}, {2'b11, 32'h0000_0003, 32'h0000_0003},
      {2'b10, 32'h0000_7FFF, 32'h0000_8000}};

   acb_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .exe_req(req), .exe_sub(sub), .exe_wide(wide),
      .exe_opnd_a(opa), .exe_opnd_b(opb), .res_valid(vld), .res_word(word),
      .res_carry(cry), .res_borrow(brw), .res_zero(zro), .irq(irq));
   acb_exec_model mdl_u (.exe_req(req), .exe_sub(sub), .exe_wide(wide),
      .exe_opnd_a(opa), .exe_opnd_b(opb));

   // verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // bus write, both channels offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic at, wt, bt;
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         {at, wt, bt} = {awvalid & awready, wvalid & wready, bvalid};
         if (bt) check("bresp", {30'h0, bresp}, {30'h0, er});
         @(posedge aclk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         if (bt) break;
      end
      bready <= 1'b0;
      if (n == 50) begin
         fail_count++;
         complete_run();
      end
   endtask

   // bus read, compared against expected data and response
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int   n;
      logic at, rt;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         {at, rt} = {arvalid & arready, rvalid};
         if (rt) check("rdata", rdata, ed);
         if (rt) check("rresp", {30'h0, rresp}, {30'h0, er});
         @(posedge aclk);
         if (at) arvalid <= 1'b0;
         if (rt) break;
      end
      rready <= 1'b0;
      if (n == 50) begin
         fail_count++;
         complete_run();
      end
   endtask

   // reference: {zero, borrow, carry, word}
   function automatic logic [34:0] ref_op(input logic [65:0] c);
      longint ta, tb, t, lim;
      logic   cf, bf;
      logic [31:0] w;
      lim = c[64] ? 64'sd2147483648 : 64'sd32768;
      ta = c[64] ? longint'($signed(c[63:32])) : longint'($signed(c[47:32]));
      tb = c[64] ? longint'($signed(c[31:0])) : longint'($signed(c[15:0]));
      t = c[65] ? ta - tb : ta + tb;
      cf = t > lim - 1;
      bf = t < -lim;
      t = t - (cf ? lim : 0) + (bf ? lim : 0);
      w = c[64] ? t[31:0] : {16'h0, t[15:0]};
      return {w == 0 && !cf && !bf, bf, cf, w};
   endfunction

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   initial begin : main
      logic [34:0] e;
      int          i;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axr(acb_pkg::ACB_OFF_CTRL, 32'h0, 2'h0);
      axr(acb_pkg::ACB_OFF_IMASK, 32'h0, 2'h0);
      // back-to-back executor ops, each checked the cycle after
      for (i = 0; i <= 9; i++) begin
         @(posedge aclk);
         if (i < 9) mdl_u.issue(cs[i][65], cs[i][64], cs[i][63:0]);
         else mdl_u.rest();
         #1;
         if (i > 0) begin
            e = ref_op(cs[i-1]);
            check("valid", vld, 1);
            check("word", word, e[31:0]);
            check("carry", cry, e[32]);
            check("borrow", brw, e[33]);
            check("zero", zro, e[34]);
         end
      end
      repeat (3) @(posedge aclk);
      #1;
      check("hold_word", word, e[31:0]);
      check("idle_valid", vld, 0);
      // events, mask and clear
      axr(acb_pkg::ACB_OFF_ISTAT, 32'h7, 2'h0);
      check("irq_masked", irq, 0);
      axw(acb_pkg::ACB_OFF_IMASK, 32'h7, 2'h0);
      repeat (2) @(posedge aclk);
      #1;
      check("irq_on", irq, 1);
      axw(acb_pkg::ACB_OFF_ISTAT, 32'h7, 2'h0);
      repeat (2) @(posedge aclk);
      #1;
      check("irq_off", irq, 0);
      axr(acb_pkg::ACB_OFF_ISTAT, 32'h0, 2'h0);
      // software op and unmapped offsets
      axw(acb_pkg::ACB_OFF_CTRL, 32'hFFFF_FFFF, 2'h0);
      axr(acb_pkg::ACB_OFF_CTRL, 32'h3, 2'h0);
      axw(acb_pkg::ACB_OFF_OPA, 32'h8000_0000, 2'h0);
      axw(acb_pkg::ACB_OFF_OPB, 32'h1, 2'h0);
      axw(acb_pkg::ACB_OFF_CMD, 32'h1, 2'h0);
      repeat (3) @(posedge aclk);
      axr(acb_pkg::ACB_OFF_RESULT, 32'hFFFF_FFFF, 2'h0);
      axr(acb_pkg::ACB_OFF_FLAGS, 32'h2, 2'h0);
      axr(8'h20, 32'h0, acb_pkg::ACB_RESP_SLV);
      axw(8'h24, 32'h1, acb_pkg::ACB_RESP_SLV);
      complete_run();
   end
endmodule // acb_unit_test

`default_nettype wire
